// *** bench/reader_model.sv ***
// reader side: classic wishbone master issuing login and page commands
// assumes one clock shared with the page access block
`timescale 1ns/10ps

module reader_model (
	// clock
	input wire logic clk,
	// wishbone master
	output logic cyc,
	output logic stb,
	output logic we,
	output logic [7:0] adr,
	output logic [3:0] sel,
	output logic [31:0] wdat,
	input wire logic [31:0] rdat,
	input wire logic ack
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hF;
		wdat = 32'h0000_0000;
	end
	// every word goes whole; the tag value read back is taken as is
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic ok);
		int n;
		ok = 1'b0;
		q = 32'h0000_0000;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		wdat <= d;
		for (n = 0; n < 20 && !ok; n++) begin
			@(posedge clk);
			ok = (ack === 1'b1);
			q = rdat;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		// released lines show garbage, not the last value
		adr <= ~a;
		wdat <= ~d;
		@(posedge clk);
	endtask
endmodule

// *** bench/transponder_page_access_control_tb.sv ***
// self-checking bench for the page access block
// assumes reader_model as bus master and default parameters
`timescale 1ns/10ps
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
	$display("ERROR %s expected %h seen %h", nm, e, a); end end

module transponder_page_access_control_tb;
	import tpac_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cyc, stb, we, ack, auth_open;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, q;
	logic [23:0] tag_pw;
	cfg_s cfg;
	int num_errors = 0;
	int comparisons = 0;

	initial begin
		forever #5 clk_sys = ~clk_sys;
	end

	transponder_page_access_control dut (.CLK_SYS(clk_sys), .RST_N(rst_n), .WB_CYC(cyc),
		.WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(sel), .WB_WDATA(wdat),
		.WB_RDATA(rdat), .WB_ACK(ack), .CFG(cfg), .AUTH_OPEN(auth_open), .TAG_PW(tag_pw));
	reader_model rdr (.clk(clk_sys), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
		.wdat(wdat), .rdat(rdat), .ack(ack));

	task automatic complete_run;
		$display("checks %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		logic ok;
		rdr.xfer(w, a, d, q, ok);
		if (!ok) begin
			num_errors++;
			$display("ERROR ack expected 1 seen 0");
			complete_run();
		end
	endtask

	task automatic t_login;
		#1;
		`CHK("cfg", 8'h06, cfg)
		`CHK("tag", 24'h0, tag_pw)
		bus(1'b0, 8'h04, 0);
		`CHK("pg1 shut", 32'h0, q)
		bus(1'b1, 8'h20, 32'h4D49_4B52);
		#1;
		`CHK("open", 1'b1, auth_open)
		bus(1'b0, 8'h04, 0);
		`CHK("pg1", 32'h4D49_4B52, q)
		bus(1'b1, 8'h00, 32'hFFFF_FFFF);
		bus(1'b0, 8'h00, 0);
		`CHK("pg0", 32'h1357_9BDF, q)
		bus(1'b0, 8'h2C, 0);
		`CHK("tagreg", 32'h00AA_4854, q)
		`CHK("tagport", 24'hAA_4854, tag_pw)
		$display("test login done");
	endtask

	task automatic t_user_lock;
		bus(1'b1, 8'h10, 32'h1111_0004);
		bus(1'b1, 8'h08, 32'h5A5A_0002);
		bus(1'b1, 8'h0C, 32'h26AA_4854);
		bus(1'b1, 8'h10, 32'hDEAD_0004);
		bus(1'b1, 8'h18, 32'h2222_0006);
		bus(1'b0, 8'h10, 0);
		`CHK("pg4", 32'h1111_0004, q)
		bus(1'b0, 8'h18, 0);
		`CHK("pg6", 32'h2222_0006, q)
		`CHK("cfg5", 8'h26, cfg)
		$display("test user lock done");
	endtask

	task automatic t_otp;
		bus(1'b1, 8'h0C, 32'hA6AA_4854);
		bus(1'b1, 8'h0C, 32'h26AA_4854);
		bus(1'b0, 8'h0C, 0);
		`CHK("otp7", 32'hA6AA_4854, q)
		bus(1'b1, 8'h0C, 32'hE6AA_4854);
		bus(1'b1, 8'h0C, 32'h0612_3456);
		bus(1'b0, 8'h0C, 0);
		`CHK("pg3", 32'hE6AA_4854, q)
		bus(1'b0, 8'h04, 0);
		`CHK("pg1 lock", 32'h0, q)
		bus(1'b1, 8'h08, 32'h0);
		bus(1'b0, 8'h08, 0);
		`CHK("pg2", 32'h5A5A_0002, q)
		`CHK("cfg otp", 8'hE6, cfg)
		$display("test otp done");
	endtask

	task automatic t_status;
		bus(1'b0, 8'h28, 0);
		`CHK("status", 32'h0000_0003, q)
		bus(1'b1, 8'h28, 32'h0000_0006);
		bus(1'b0, 8'h28, 0);
		`CHK("status clr", 32'h0000_0001, q)
		bus(1'b1, 8'h20, 32'h0000_0000);
		`CHK("bad key", 1'b0, auth_open)
		bus(1'b0, 8'h28, 0);
		`CHK("fail flag", 32'h0000_0004, q)
		bus(1'b1, 8'h20, 32'h4D49_4B52);
		bus(1'b1, 8'h24, 32'h0000_0001);
		`CHK("logout", 1'b0, auth_open)
		bus(1'b0, 8'h2C, 0);
		`CHK("tag closed", 32'h0, q)
		`CHK("tagport closed", 24'h0, tag_pw)
		$display("test status done");
	endtask

	task automatic t_crypto;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		#1;
		`CHK("cfg rst", 8'h06, cfg)
		`CHK("closed rst", 1'b0, auth_open)
		bus(1'b1, 8'h20, 32'h4D49_4B52);
		bus(1'b0, 8'h0C, 0);
		`CHK("pg3 rst", 32'h06AA_4854, q)
		bus(1'b1, 8'h0C, 32'h8EAA_4854);
		bus(1'b0, 8'h08, 0);
		`CHK("pg2 crypto", 32'h0, q)
		`CHK("cfg crypto", 8'h8E, cfg)
		$display("test crypto done");
	endtask

	initial begin
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		t_login();
		t_user_lock();
		t_otp();
		t_status();
		t_crypto();
		complete_run();
	end
endmodule

// *** rtl/tpac_params.svh ***
// offsets, field positions, reset values for the page access block
// assumes byte addressing on a 32-bit classic wishbone slave port
`ifndef TPAC_PARAMS_SVH
`define TPAC_PARAMS_SVH
// page numbers
`define PG_SERIAL 3'h0
`define PG_RDR_PW 3'h1
`define PG_RSVD 3'h2
`define PG_CFG 3'h3
`define PG_USER_LO_A 3'h4
`define PG_USER_LO_B 3'h5
`define PG_USER_HI_A 3'h6
`define PG_USER_HI_B 3'h7
// word index inside the 64-byte window (byte address = 4 x index)
`define RI_KEY 4'h8
`define RI_CTRL 4'h9
`define RI_STATUS 4'hA
`define RI_TAGPW 4'hB
`define OFS_PAGE0 8'h00
`define OFS_KEY 8'h20
`define OFS_CTRL 8'h24
`define OFS_STATUS 8'h28
`define OFS_TAGPW 8'h2C
// reset values
`define RDR_PW_RST 32'h4D49_4B52
`define TAG_PW_RST 24'hAA_4854
`define CFG_RST 8'h06
`define PAGE_CLR 32'h0000_0000
// field positions
`define CFG_MSB 31
`define CFG_LSB 24
`define TAG_MSB 23
`define OTP_MSB 31
`define OTP_LSB 30
`define CTRL_B_LOGOUT 0
`define ST_B_OPEN 0
`define ST_B_REFUSED 1
`define ST_B_LOGFAIL 2
`endif

// *** rtl/tpac_pkg.sv ***
// types of the page access block
// assumes tpac_params.svh for all numeric constants
package tpac_pkg;
	// configuration byte, bit 7 first
	typedef struct packed {
		logic lock_secret;
		logic lock_cfg;
		logic lock_user_lo;
		logic lock_user_hi;
		logic crypto;
		logic [1:0] op_mode;
		logic biphase;
	} cfg_s;
	typedef enum logic [1:0] {
		ST_LOCKED = 2'b01,
		ST_OPEN = 2'b10
	} auth_e;
endpackage

// *** rtl/transponder_page_access_control.sv ***
// page store with login gate and configuration-driven page locks
// assumes a classic wishbone master on CLK_SYS and one synchronous clock
//
// Behaviour
// - eight 32-bit pages: 0 fixed serial, 1 reader secret, 2 reserved, 3 config+tag key, 4-7 user.
// - after reset page 1 holds 4D494B52h and the tag key field AA4854h, both rewritable.
// - page 3 keeps the tag key in bits 23:0 and the config byte in 31:24; writes replace the byte, bits 7 and 6 only rising.
// - no page is reached until a login with the reader secret has succeeded.
// - the tag key is presented to the reader after login, and the reader takes any value.
// - config bit 7 set forbids page 1 fully and leaves page 2 read-only, or closed in crypto mode.
// - config bit 6 set makes page 3 read-only, freezing config byte and tag key.
// - config bit 5 makes pages 4,5 read-only and bit 4 pages 6,7; at 0 they are writable.
// - config bits 7 and 6, once 1, return to 0 only on reset.
// - config bit 3 selects password mode at 0 and crypto mode at 1, reset 0.
// - config bits 2,1 select the operating mode, reset 11 (native mode).
// - config bit 0 selects native line coding, 0 manchester, 1 biphase, reset 0.
`timescale 1ns/10ps
`include "tpac_params.svh"

module transponder_page_access_control
	import tpac_pkg::*;
#(
	parameter int ADR_W = 8,
	// serial number value is arbitrary
	parameter logic [31:0] SERIAL_NUMBER = 32'h1357_9BDF
) (
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// wishbone slave
	input wire logic WB_CYC,
	input wire logic WB_STB,
	input wire logic WB_WE,
	input wire logic [ADR_W-1:0] WB_ADR,
	input wire logic [3:0] WB_SEL,
	input wire logic [31:0] WB_WDATA,
	output logic [31:0] WB_RDATA,
	output logic WB_ACK,
	// device side
	output cfg_s CFG,
	output logic AUTH_OPEN,
	output logic [23:0] TAG_PW
);

	if (ADR_W < 7) begin : g_bad_adr
		$error("ADR_W must be at least 7");
	end

	logic req;
	logic take;
	logic hit;
	logic [3:0] word;
	logic is_page;
	logic [2:0] pg;
	logic rd_ok;
	logic wr_ok;
	logic open;
	logic [31:0] pages [1:7];
	logic [31:0] merged;
	logic [31:0] next_rdata;
	logic page_wr;
	logic key_wr;
	logic refused;
	logic login_fail;
	cfg_s cfg;
	auth_e auth;

	assign req = WB_CYC & WB_STB;
	// write lands on the edge where the master samples ack
	assign take = req & WB_ACK;
	assign hit = (WB_ADR[ADR_W-1:6] == '0);
	assign word = WB_ADR[5:2];
	assign is_page = hit & ~word[3];
	assign pg = word[2:0];
	assign open = (auth == ST_OPEN);
	assign cfg = cfg_s'(pages[`PG_CFG][`CFG_MSB:`CFG_LSB]);
	assign AUTH_OPEN = open;

	// per-page access from the current config byte
	always_comb begin
		rd_ok = 1'b0;
		wr_ok = 1'b0;
		case (pg)
			`PG_SERIAL: begin
				rd_ok = 1'b1;
				wr_ok = 1'b0;
			end
			`PG_RDR_PW: begin
				rd_ok = ~cfg.lock_secret;
				wr_ok = ~cfg.lock_secret;
			end
			`PG_RSVD: begin
				rd_ok = ~cfg.lock_secret | ~cfg.crypto;
				wr_ok = ~cfg.lock_secret;
			end
			`PG_CFG: begin
				rd_ok = 1'b1;
				wr_ok = ~cfg.lock_cfg;
			end
			`PG_USER_LO_A, `PG_USER_LO_B: begin
				rd_ok = 1'b1;
				wr_ok = ~cfg.lock_user_lo;
			end
			`PG_USER_HI_A, `PG_USER_HI_B: begin
				rd_ok = 1'b1;
				wr_ok = ~cfg.lock_user_hi;
			end
			default: begin
				rd_ok = 1'b0;
				wr_ok = 1'b0;
			end
		endcase
		if (!open) begin
			rd_ok = 1'b0;
			wr_ok = 1'b0;
		end
	end

	// byte-lane merge; the protected config bits can only be raised
	always_comb begin
		merged = `PAGE_CLR;
		if (pg != `PG_SERIAL) begin
			merged = pages[pg];
		end
		for (int b = 0; b < 4; b++) begin
			if (WB_SEL[b]) begin
				merged[8*b +: 8] = WB_WDATA[8*b +: 8];
			end
		end
		if (pg == `PG_CFG) begin
			merged[`OTP_MSB:`OTP_LSB] = merged[`OTP_MSB:`OTP_LSB]
				| pages[`PG_CFG][`OTP_MSB:`OTP_LSB];
		end
	end

	assign page_wr = take & WB_WE & is_page & wr_ok & (pg != `PG_SERIAL);
	assign key_wr = take & WB_WE & hit & (word == `RI_KEY) & (WB_SEL == 4'hF);

	// page store; page 0 is the fixed serial and is never stored
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 1; i < 8; i++) begin
				if (i == 1) begin
					pages[i] <= `RDR_PW_RST;
				end else if (i == 3) begin
					pages[i] <= {`CFG_RST, `TAG_PW_RST};
				end else begin
					pages[i] <= `PAGE_CLR;
				end
			end
		end else if (page_wr) begin
			pages[pg] <= merged;
		end
	end

	// login state
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			auth <= ST_LOCKED;
		end else begin
			case (auth)
				ST_LOCKED: begin
					if (key_wr && WB_WDATA == pages[`PG_RDR_PW]) begin
						auth <= ST_OPEN;
					end
				end
				ST_OPEN: begin
					if (key_wr && WB_WDATA != pages[`PG_RDR_PW]) begin
						auth <= ST_LOCKED;
					end else if (take && WB_WE && hit && word == `RI_CTRL
						&& WB_SEL[0] && WB_WDATA[`CTRL_B_LOGOUT]) begin
						auth <= ST_LOCKED;
					end
				end
				default: auth <= ST_LOCKED;
			endcase
		end
	end

	// sticky status, write one to clear; a new event wins over the clear
	logic st_clr;
	logic refuse_evt;
	logic fail_evt;
	assign st_clr = take & WB_WE & hit & (word == `RI_STATUS) & WB_SEL[0];
	assign refuse_evt = take & is_page & (WB_WE ? ~(wr_ok & (pg != `PG_SERIAL)) : ~rd_ok);
	assign fail_evt = key_wr & (WB_WDATA != pages[`PG_RDR_PW]);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			refused <= 1'b0;
			login_fail <= 1'b0;
		end else begin
			refused <= refuse_evt | (refused & ~(st_clr & WB_WDATA[`ST_B_REFUSED]));
			login_fail <= fail_evt | (login_fail & ~(st_clr & WB_WDATA[`ST_B_LOGFAIL]));
		end
	end

	// read mux; unmapped words read zero
	always_comb begin
		next_rdata = `PAGE_CLR;
		if (is_page) begin
			if (rd_ok) begin
				next_rdata = (pg == `PG_SERIAL) ? SERIAL_NUMBER : pages[pg];
			end
		end else if (hit) begin
			case (word)
				`RI_STATUS: begin
					next_rdata[`ST_B_OPEN] = open;
					next_rdata[`ST_B_REFUSED] = refused;
					next_rdata[`ST_B_LOGFAIL] = login_fail;
				end
				`RI_TAGPW: begin
					if (open) begin
						next_rdata[`TAG_MSB:0] = pages[`PG_CFG][`TAG_MSB:0];
					end
				end
				default: next_rdata = `PAGE_CLR;
			endcase
		end
	end

	// one wait state: ack one cycle after the request, dropped after
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			WB_ACK <= 1'b0;
			WB_RDATA <= `PAGE_CLR;
		end else begin
			WB_ACK <= req & ~WB_ACK;
			if (req && !WB_ACK) begin
				WB_RDATA <= next_rdata;
			end
		end
	end

	// device-side copies; mode fields pass on unfiltered
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			CFG <= cfg_s'(`CFG_RST);
			TAG_PW <= 24'h00_0000;
		end else begin
			CFG <= cfg;
			TAG_PW <= open ? pages[`PG_CFG][`TAG_MSB:0] : 24'h00_0000;
		end
	end

	// flat view of the whole store, so one check covers every page
	logic [255:0] store_flat;
	assign store_flat = {pages[7], pages[6], pages[5], pages[4], pages[3], pages[2], pages[1],
		SERIAL_NUMBER};

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	chk_serial_read: assert property (
		req && !WB_ACK && !WB_WE && is_page && pg == `PG_SERIAL && open
		|=> WB_RDATA == SERIAL_NUMBER)
		else $error("serial page read wrong");
	chk_login_gate: assert property (
		req && !WB_ACK && !WB_WE && is_page && !open |=> WB_RDATA == 32'h0 ##1 refused)
		else $error("page read without login");
	chk_secret_lock: assert property (
		take && WB_WE && is_page && pg == `PG_RDR_PW && cfg.lock_secret
		|=> $stable(pages[`PG_RDR_PW]))
		else $error("locked secret page changed");
	chk_cfg_lock: assert property (
		cfg.lock_cfg |=> $stable(pages[`PG_CFG]))
		else $error("frozen page 3 changed");
	chk_user_lock: assert property (
		take && WB_WE && is_page && (pg == `PG_USER_HI_A) && cfg.lock_user_hi
		|=> $stable(pages[`PG_USER_HI_A]))
		else $error("read-only user page changed");
	chk_otp_bits: assert property (
		cfg.lock_secret |=> cfg.lock_secret [*2])
		else $error("otp bit cleared");
	chk_tag_out: assert property (
		open && $stable(pages[`PG_CFG]) |=> TAG_PW == $past(pages[`PG_CFG][`TAG_MSB:0]))
		else $error("tag key output wrong");
	chk_cfg_out: assert property (
		##1 CFG == cfg_s'($past(pages[`PG_CFG][`CFG_MSB:`CFG_LSB])))
		else $error("config output lags");
	chk_refused_wr: assert property (
		take && WB_WE && is_page && !wr_ok |=> $stable(store_flat))
		else $error("refused write changed store");
	chk_ack_pulse: assert property (
		WB_ACK |=> !WB_ACK)
		else $error("ack longer than one cycle");
	chk_ack_wait: assert property (
		req && !WB_ACK |=> WB_ACK)
		else $error("ack not one cycle after request");

	chk_wrong_key: assert property (
		key_wr && WB_WDATA != pages[`PG_RDR_PW] |=> !open && login_fail)
		else $error("wrong key left access open");
	chk_good_key: assert property (
		key_wr && WB_WDATA == pages[`PG_RDR_PW] |=> open)
		else $error("right key did not open");
	chk_logout_cmd: assert property (
		take && WB_WE && hit && word == `RI_CTRL && WB_SEL[0] && WB_WDATA[`CTRL_B_LOGOUT]
		|=> !open)
		else $error("logout ignored");
	chk_otp_write: assert property (
		page_wr && pg == `PG_CFG
		|=> &(pages[`PG_CFG][`OTP_MSB:`OTP_LSB] | ~$past(pages[`PG_CFG][`OTP_MSB:`OTP_LSB])))
		else $error("otp bit cleared by write");
	chk_cfg_write: assert property (
		page_wr && pg == `PG_CFG && WB_SEL == 4'hF
		|=> pages[`PG_CFG][`TAG_MSB:0] == $past(WB_WDATA[`TAG_MSB:0]))
		else $error("tag key not stored in low bits");
	chk_page2_ro: assert property (
		take && WB_WE && is_page && pg == `PG_RSVD && cfg.lock_secret
		|=> $stable(pages[`PG_RSVD]))
		else $error("read-only page 2 changed");
	chk_crypto_page2: assert property (
		req && !WB_ACK && !WB_WE && is_page && pg == `PG_RSVD
		&& cfg.lock_secret && cfg.crypto |=> WB_RDATA == 32'h0000_0000)
		else $error("page 2 readable in crypto mode");
	chk_secret_hidden: assert property (
		req && !WB_ACK && !WB_WE && is_page && pg == `PG_RDR_PW && cfg.lock_secret
		|=> WB_RDATA == 32'h0000_0000)
		else $error("locked secret page readable");
	chk_tag_hidden: assert property (
		!open |=> TAG_PW == 24'h00_0000)
		else $error("tag key shown without login");
	chk_serial_wr: assert property (
		take && WB_WE && is_page && pg == `PG_SERIAL |=> refused)
		else $error("serial page write not refused");
	chk_lo_lock: assert property (
		take && WB_WE && is_page && pg == `PG_USER_LO_B && cfg.lock_user_lo
		|=> $stable(pages[`PG_USER_LO_B]))
		else $error("read-only low user page changed");
	chk_flag_set: assert property (
		refuse_evt |=> refused)
		else $error("refused flag lost to clear");

	cov_login: cover property ($rose(open));
	cov_lock_hit: cover property (take && WB_WE && is_page && open && !wr_ok);
	cov_otp_set: cover property ($rose(cfg.lock_cfg));
	cov_crypto_closed: cover property (take && pg == `PG_RSVD && open && !rd_ok);
	cov_logout: cover property ($fell(open));

endmodule
